// *** shared/rdl_pkg.sv ***
// Constants for the receive data link output block: register map, fields, timing.
// Assumes a 200 MHz system clock and a 32-bit APB register bus.
// Operation
// (R1) External receiver selected: shared pin carries the serial link bit.
// (R2) Serial bits are the three C-bits of subframe 5 from the framer.
// (R3) Without C-bit parity mode the serial bit stays high.
// (R4) Serial bit changes only on the falling edge of the link bit clock.
// (R5) Internal receiver selected: shared pin carries the message-end indication.
// (R6) Message end asserts on last byte read or receiver buffer overrun.
// (R7) Message end changes only on a falling edge of the overhead clock.
// (R8) Reading the receiver interrupt status register deasserts message end.
// (R9) Message end resets to active-low open drain; configurable active high.
// (R10) With external DMA, board wire-ORs open-drain message end onto host interrupt.
// (R11) Link bit clock from overhead clock, three cycles per frame, low 1.9 us.
// (R12) Open drain: released while deasserted, pulled low only while asserted.
package rdl_pkg;

	// Register byte offsets
	localparam logic [7:0] CTRL_OFS     = 8'h00;
	localparam logic [7:0] STATE_OFS    = 8'h04;
	localparam logic [7:0] INT_STAT_OFS = 8'h08;
	localparam logic [7:0] INT_CLR_OFS  = 8'h0C;
	localparam logic [7:0] INT_EN_OFS   = 8'h10;

	// Control fields
	localparam int CTRL_EXT_SEL_BIT = 0;
	localparam int CTRL_CBIT_BIT    = 1;
	localparam int CTRL_ACT_HI_BIT  = 2;
	localparam logic [2:0] CTRL_RESET = 3'h0;

	// Interrupt event fields
	localparam int INT_EOM_BIT   = 0;
	localparam int INT_OVR_BIT   = 1;
	localparam int INT_LBIT_BIT  = 2;
	localparam int INT_WIDTH     = 3;
	localparam logic [2:0] INT_RESET = 3'h0;

	// Link bit clock low time
	localparam int CLK_PERIOD_PS = 5000;
	localparam int LINK_LOW_NS   = 1900;
	localparam int LINK_LOW_CYCLES = (LINK_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int LOW_CNT_W     = 9;

	// Link bit clock phase
	typedef enum logic [0:0] {
		LC_HIGH = 1'b0,
		LC_LOW  = 1'b1
	} rdl_lclk_t;

endpackage

// *** hw/rdl_top.sv ***
// Receive data link outputs: serial link bit and clock, or message-end pin, plus APB regs.
// Assumes framer, receiver and overhead clock inputs are synchronous to clk.
`timescale 1ns/1ps
module rdl_top #(
	parameter int LOW_CYCLES = rdl_pkg::LINK_LOW_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        clk_en,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        rx_overhead_clock,
	input  wire logic        dl_bit_strobe,
	input  wire logic        dl_bit,
	input  wire logic        last_byte_read,
	input  wire logic        buffer_overrun,
	input  wire logic        int_status_read,
	output logic             rx_link_bit_clock,
	output logic             rx_link_pin_o,
	output logic             rx_link_pin_oe_n,
	output logic             irq
);

	logic [2:0]                     ctrl_r;
	logic [rdl_pkg::INT_WIDTH-1:0]  int_stat_r;
	logic [rdl_pkg::INT_WIDTH-1:0]  int_en_r;
	logic                           oh_prev_r;
	logic                           oh_fall;
	logic                           pend_valid_r;
	logic                           pend_bit_r;
	rdl_pkg::rdl_lclk_t             lclk_r;
	logic [rdl_pkg::LOW_CNT_W-1:0]  low_cnt_r;
	logic                           serial_bit_r;
	logic                           eom_pend_r;
	logic                           eom_level_r;
	logic                           lbit_event;
	logic                           eom_event;
	logic                           ext_sel;
	logic                           cbit_en;
	logic                           act_hi;
	logic                           apb_setup;
	logic                           apb_commit;
	logic [31:0]                    rd_nxt;
	logic                           err_nxt;
	logic                           pin_o_nxt;
	logic                           pin_oe_n_nxt;
	logic                           low_done;

	assign ext_sel = ctrl_r[rdl_pkg::CTRL_EXT_SEL_BIT];
	assign cbit_en = ctrl_r[rdl_pkg::CTRL_CBIT_BIT];
	assign act_hi  = ctrl_r[rdl_pkg::CTRL_ACT_HI_BIT];

	// APB phases: first access cycle decodes, second completes
	assign apb_setup  = psel && penable && !pready;
	assign apb_commit = psel && penable && pready;

	// Falling edge of the overhead clock, sampled as an ordinary input
	assign oh_fall  = oh_prev_r && !rx_overhead_clock;
	assign low_done = low_cnt_r >= LOW_CYCLES[rdl_pkg::LOW_CNT_W-1:0];

	// Message-end event from the internal receiver
	assign eom_event  = last_byte_read || buffer_overrun; // R6
	assign lbit_event = oh_fall && (lclk_r == rdl_pkg::LC_HIGH) && pend_valid_r;

	// Overhead clock edge history
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			oh_prev_r <= 1'b0;
		else if (clk_en)
			oh_prev_r <= rx_overhead_clock;
	end

	// Read data and error decode
	always_comb
	begin
		rd_nxt  = 32'h0000_0000;
		err_nxt = 1'b0;
		if (paddr == rdl_pkg::CTRL_OFS)
			rd_nxt[2:0] = ctrl_r;
		else if (paddr == rdl_pkg::STATE_OFS)
			rd_nxt[3:0] = {pend_valid_r, serial_bit_r, lclk_r == rdl_pkg::LC_HIGH, eom_pend_r};
		else if (paddr == rdl_pkg::INT_STAT_OFS)
			rd_nxt[2:0] = int_stat_r;
		else if (paddr == rdl_pkg::INT_CLR_OFS)
			rd_nxt = 32'h0000_0000; // Write-only, reads zero
		else if (paddr == rdl_pkg::INT_EN_OFS)
			rd_nxt[2:0] = int_en_r;
		else
			err_nxt = 1'b1;
	end

	// APB answer: one wait state, data held while pready is high
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else if (clk_en)
		begin
			pready  <= apb_setup;
			pslverr <= apb_setup && err_nxt;
			if (apb_setup)
				prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
		end
	end

	// Control register
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			ctrl_r <= rdl_pkg::CTRL_RESET; // R9
		else if (clk_en && apb_commit && pwrite && paddr == rdl_pkg::CTRL_OFS)
			ctrl_r <= pwdata[2:0];
	end

	// Interrupt enable register
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			int_en_r <= rdl_pkg::INT_RESET;
		else if (clk_en && apb_commit && pwrite && paddr == rdl_pkg::INT_EN_OFS)
			int_en_r <= pwdata[2:0];
	end

	// Sticky interrupt status; a new event wins over a clear
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			int_stat_r <= rdl_pkg::INT_RESET;
		else if (clk_en)
		begin
			if (apb_commit && pwrite && paddr == rdl_pkg::INT_CLR_OFS)
				int_stat_r <= int_stat_r & ~pwdata[2:0] | {lbit_event, buffer_overrun, eom_event};
			else
				int_stat_r <= int_stat_r | {lbit_event, buffer_overrun, eom_event};
		end
	end

	// Level interrupt from enabled status bits
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			irq <= 1'b0;
		else if (clk_en)
			irq <= |(int_stat_r & int_en_r);
	end

	// Hold the next framer bit until the link clock can take it
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			pend_valid_r <= 1'b0;
			pend_bit_r   <= 1'b1;
		end
		else if (clk_en)
		begin
			if (dl_bit_strobe)
			begin
				pend_valid_r <= 1'b1;
				pend_bit_r   <= dl_bit; // R2
			end
			else if (lbit_event)
				pend_valid_r <= 1'b0;
		end
	end

	// Link bit clock: falls with each bit, rises after the low time
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			lclk_r    <= rdl_pkg::LC_HIGH;
			low_cnt_r <= '0;
		end
		else if (clk_en)
		begin
			case (lclk_r)
				rdl_pkg::LC_HIGH:
				begin
					if (lbit_event) // R11
					begin
						lclk_r    <= rdl_pkg::LC_LOW;
						low_cnt_r <= '0;
					end
				end
				rdl_pkg::LC_LOW:
				begin
					if (!low_done)
						low_cnt_r <= low_cnt_r + 1'b1;
					if (oh_fall && low_done) // R11
						lclk_r <= rdl_pkg::LC_HIGH;
				end
				default:
					lclk_r <= rdl_pkg::LC_HIGH;
			endcase
		end
	end

	// Serial bit loads as the link clock falls; held high outside parity mode
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			serial_bit_r <= 1'b1;
		else if (clk_en)
		begin
			if (!cbit_en)
				serial_bit_r <= 1'b1; // R3
			else if (lbit_event)
				serial_bit_r <= pend_bit_r; // R2 R4
		end
	end

	// Message-end pending: event wins over the status read
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			eom_pend_r <= 1'b0;
		else if (clk_en)
		begin
			if (eom_event)
				eom_pend_r <= 1'b1; // R6
			else if (int_status_read)
				eom_pend_r <= 1'b0; // R8
		end
	end

	// Visible message-end level follows pending on overhead clock falls
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			eom_level_r <= 1'b0;
		else if (clk_en && oh_fall)
			eom_level_r <= eom_pend_r; // R7
	end

	// Shared pin mux and drive style
	always_comb
	begin
		pin_o_nxt    = 1'b0;
		pin_oe_n_nxt = 1'b1;
		if (ext_sel)
		begin
			pin_o_nxt    = serial_bit_r; // R1
			pin_oe_n_nxt = 1'b0;
		end
		else if (act_hi)
		begin
			pin_o_nxt    = eom_level_r; // R5 R9
			pin_oe_n_nxt = 1'b0;
		end
		else
		begin
			pin_o_nxt    = 1'b0;
			pin_oe_n_nxt = !eom_level_r; // R5 R12
		end
	end

	// Registered pin and link clock outputs
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			rx_link_pin_o     <= 1'b0;
			rx_link_pin_oe_n  <= 1'b1;
			rx_link_bit_clock <= 1'b1;
		end
		else if (clk_en)
		begin
			rx_link_pin_o     <= pin_o_nxt;
			rx_link_pin_oe_n  <= pin_oe_n_nxt;
			rx_link_bit_clock <= (lclk_r == rdl_pkg::LC_HIGH);
		end
	end

	// Pin follows serial bit when the external receiver is selected
	chk_pin_serial_mode: assert property (@(posedge clk) disable iff (!rst_b) // R1
		clk_en && ext_sel |=> !rx_link_pin_oe_n && rx_link_pin_o == $past(serial_bit_r))
		else $error("pin not driving serial bit");

	// Loaded serial bit equals the held framer bit
	chk_serial_bit_value: assert property (@(posedge clk) disable iff (!rst_b) // R2
		clk_en && cbit_en && lbit_event |=> serial_bit_r == $past(pend_bit_r))
		else $error("serial bit not taken from framer");

	// Serial bit forced high outside parity mode
	chk_serial_held_high: assert property (@(posedge clk) disable iff (!rst_b) // R3
		clk_en && !cbit_en |=> serial_bit_r)
		else $error("serial bit not high outside parity mode");

	// Serial bit changes only as the link clock falls
	chk_serial_on_fall: assert property (@(posedge clk) disable iff (!rst_b) // R4
		$changed(serial_bit_r) && $past(cbit_en) |-> $past(lbit_event) && lclk_r == rdl_pkg::LC_LOW)
		else $error("serial bit changed off the link clock fall");

	// Open-drain message end in internal mode
	chk_pin_open_drain: assert property (@(posedge clk) disable iff (!rst_b) // R12
		clk_en && !ext_sel && !act_hi |=> !rx_link_pin_o && rx_link_pin_oe_n == !$past(eom_level_r))
		else $error("open-drain message end wrong");

	// Active-high message end in internal mode
	chk_pin_active_high: assert property (@(posedge clk) disable iff (!rst_b) // R5
		clk_en && !ext_sel && act_hi |=> !rx_link_pin_oe_n && rx_link_pin_o == $past(eom_level_r))
		else $error("active-high message end wrong");

	// Event raises message end pending
	chk_eom_set: assert property (@(posedge clk) disable iff (!rst_b) // R6
		clk_en && (last_byte_read || buffer_overrun) |=> eom_pend_r)
		else $error("message end not raised");

	// Status read clears pending unless a new event arrives
	chk_eom_clear: assert property (@(posedge clk) disable iff (!rst_b) // R8
		clk_en && int_status_read && !eom_event |=> !eom_pend_r)
		else $error("message end not cleared by status read");

	// Visible level moves only on overhead clock falls
	chk_eom_timing: assert property (@(posedge clk) disable iff (!rst_b) // R7
		$changed(eom_level_r) |-> $past(oh_fall) && $past(clk_en))
		else $error("message end changed off the overhead clock fall");

	// Reset leaves the pin open-drain and released
	chk_reset_drive: assert property (@(posedge clk) // R9
		rst_b && !$past(rst_b) |-> !act_hi && rx_link_pin_oe_n && !rx_link_pin_o)
		else $error("reset drive style wrong");

	// Link clock low for the full low time and rises on an overhead fall
	chk_link_low_time: assert property (@(posedge clk) disable iff (!rst_b) // R11
		lclk_r == rdl_pkg::LC_LOW && $past(lclk_r) == rdl_pkg::LC_HIGH
		|-> !(lclk_r == rdl_pkg::LC_HIGH) [*8])
		else $error("link clock low too short");

	chk_link_rise: assert property (@(posedge clk) disable iff (!rst_b) // R11
		lclk_r == rdl_pkg::LC_HIGH && $past(lclk_r) == rdl_pkg::LC_LOW
		|-> $past(oh_fall) && $past(low_cnt_r) >= LOW_CYCLES)
		else $error("link clock rose early");

	// Interrupt output follows enabled sticky bits
	chk_irq_level: assert property (@(posedge clk) disable iff (!rst_b)
		clk_en |=> irq == |($past(int_stat_r) & $past(int_en_r)))
		else $error("interrupt output wrong");

endmodule

// *** verif/rdl_far_end.sv ***
// Far-end model: external link receiver plus the pulled-up host interrupt line.
// Assumes the design splits the shared pin into a value and an active-low enable.
`timescale 1ns/1ps
module rdl_far_end (
	input  wire logic rx_link_bit_clock,
	input  wire logic pin_o,
	input  wire logic pin_oe_n,
	output logic      pin_level,
	output logic      cap_bit
);
	// Pull-up on the shared line: a released pin reads high
	assign pin_level = pin_oe_n ? 1'b1 : pin_o;
	// Receiver samples the serial bit on the rising link clock edge
	always @(posedge rx_link_bit_clock)
	begin
		cap_bit <= pin_level;
	end
endmodule

// *** verif/rx_path_data_link_outputs_bench.sv ***
// Testbench for the receive data link outputs: APB, message end, serial link bit.
// Assumes rdl_top with a short link clock low time and the far-end model.
`timescale 1ns/1ps
module rx_path_data_link_outputs_bench;
	logic        clk, rst_b, psel, penable, pwrite, ohc, strobe, dbit, lbr, ovr, isr, ce;
	logic        pready, pslverr, err, lclk, pin_o, pin_oe_n, irq, lvl, cap, prev;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	int          fails, samples_checked, cyc, n;

	rdl_top #(.LOW_CYCLES(4)) DUT (.clk(clk), .rst_b(rst_b), .clk_en(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rx_overhead_clock(ohc), .dl_bit_strobe(strobe),
		.dl_bit(dbit), .last_byte_read(lbr), .buffer_overrun(ovr), .int_status_read(isr),
		.rx_link_bit_clock(lclk), .rx_link_pin_o(pin_o), .rx_link_pin_oe_n(pin_oe_n), .irq(irq));
	rdl_far_end far (.rx_link_bit_clock(lclk), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
		.pin_level(lvl), .cap_bit(cap));

	// System clock
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Overhead clock of eight system cycles, and the hang limit
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		ohc <= cyc[2];
		if (cyc == 30000)
		begin
			fails++;
			end_sim;
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wt(input int k);
		repeat (k) @(posedge clk);
	endtask
	// One APB transfer; holds the request until pready is sampled high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	// One-cycle event pulse: 0 last byte, 1 overrun, 2 status read, 3 link bit
	task pulse(input int s);
		@(posedge clk);
		case (s)
			0: lbr <= 1'b1;
			1: ovr <= 1'b1;
			2: isr <= 1'b1;
			default: strobe <= 1'b1;
		endcase
		@(posedge clk);
		lbr <= 1'b0; ovr <= 1'b0; isr <= 1'b0; strobe <= 1'b0;
	endtask

	// Reset state and an unmapped access
	task t_reset;
		apb(1'b0, rdl_pkg::CTRL_OFS, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		chk(pin_oe_n, 1'b1);
		apb(1'b0, 8'h20, 32'h0000_0000);
		chk(err, 1'b1);
		chk(rd, 32'h0000_0000);
	endtask
	// Open-drain message end, with interrupt enable, mask and clear
	task t_eom;
		apb(1'b1, rdl_pkg::INT_EN_OFS, 32'h0000_0001);
		@(posedge ohc);
		pulse(0);
		wt(3);
		chk(pin_oe_n, 1'b1);
		wt(9);
		chk({pin_oe_n, pin_o, lvl, irq}, 4'b0001);
		pulse(2);
		wt(12);
		chk({pin_oe_n, lvl}, 2'b11);
		apb(1'b1, rdl_pkg::INT_CLR_OFS, 32'h0000_0001);
		pulse(1);
		wt(12);
		chk(pin_oe_n, 1'b0);
		apb(1'b0, rdl_pkg::INT_STAT_OFS, 32'h0000_0000);
		chk(rd[1:0], 2'b11);
		chk(irq, 1'b1);
		pulse(2);
		apb(1'b1, rdl_pkg::INT_CLR_OFS, 32'h0000_0003);
		wt(12);
		chk({irq, pin_oe_n}, 2'b01);
	endtask
	// Active-high message end
	task t_high;
		apb(1'b1, rdl_pkg::CTRL_OFS, 32'h0000_0004);
		wt(2);
		chk({pin_oe_n, pin_o}, 2'b00);
		pulse(0);
		wt(12);
		chk(pin_o, 1'b1);
		// Frozen block ignores the status read
		ce <= 1'b0;
		pulse(2);
		wt(12);
		chk(pin_o, 1'b1);
		ce <= 1'b1;
		pulse(2);
		wt(12);
		chk(pin_o, 1'b0);
	endtask
	// One serial link bit: output moves only with the falling link clock
	task t_link(input logic par, input logic b, input logic exp);
		apb(1'b1, rdl_pkg::CTRL_OFS, {30'h0, par, 1'b1});
		wt(3);
		prev = pin_o;
		dbit <= b;
		pulse(3);
		n = 0;
		while (lclk !== 1'b0 && n < 40)
		begin
			chk(pin_o, prev);
			@(posedge clk);
			n++;
		end
		wt(1);
		chk({pin_oe_n, pin_o}, {1'b0, exp});
		n = 0;
		while (lclk === 1'b0 && n < 100)
		begin
			@(posedge clk);
			n++;
		end
		chk(n >= 4, 1'b1);
		wt(1);
		chk(cap, exp);
	endtask

	task end_sim;
		if (fails == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial
	begin
		{rst_b, psel, penable, pwrite, strobe, dbit, lbr, ovr, isr} = '0;
		ce = 1'b1;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		{fails, samples_checked} = '0;
		wt(16);
		rst_b <= 1'b1;
		t_reset;
		t_eom;
		t_high;
		t_link(1'b1, 1'b0, 1'b0);
		t_link(1'b1, 1'b1, 1'b1);
		t_link(1'b1, 1'b0, 1'b0);
		t_link(1'b0, 1'b0, 1'b1);
		end_sim;
	end
endmodule
